// [dv/aofc_capture_model.sv]
// Downstream capture register that rebuilds the plain word
`timescale 1ns/1ps
module aofc_capture_model (
   // Link from the converter
   input  wire logic                        clk_true,
   input  wire logic [aofc_pkg::DATA_W-1:0] data,
   input  wire logic                        over,
   input  wire logic                        descramble,
   // Captured result
   output aofc_pkg::aofc_word_s             word
);
   always @(posedge clk_true) begin
      word.over <= over;
      word.data <= descramble ? data ^ {{15{data[0]}}, 1'b0} : data;
   end
endmodule : aofc_capture_model

// [dv/aofc_top_assertions.sv]
// Concurrent checks on the pins, core link and parallel output of the format control block
`timescale 1ns/1ps
module aofc_top_assertions (
   // Clock and reset
   input wire logic                          hclk,
   input wire logic                          hresetn,
   // Pins and converter core
   input wire logic                          sample_clk,
   input wire logic                          gain_range_select,
   input wire logic                          core_above,
   input wire logic                          core_below,
   input wire logic [aofc_pkg::DITHER_W-1:0] dither_dac,
   input wire logic                          span_narrow,
   input wire logic                          hold_strobe,
   // Parallel output
   input wire logic [aofc_pkg::DATA_W-1:0]   data_out,
   input wire logic                          overrange_flag,
   input wire logic                          output_clock_true,
   input wire logic                          output_clock_inverted,
   input wire logic                          sample_valid
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   AST_CLK_PAIR: assert property (output_clock_inverted == !output_clock_true)
      else $error("output clock pair not complementary");
   AST_DATA_ON_FALL: assert property (!$stable(data_out) |-> $fell(output_clock_true))
      else $error("data word changed away from output clock fall");
   AST_FLAG_ON_FALL: assert property (!$stable(overrange_flag) |-> $fell(output_clock_true))
      else $error("overrange flag changed apart from the word");
   AST_VALID_ON_FALL: assert property (!$stable(sample_valid) |-> $fell(output_clock_true))
      else $error("valid marker changed apart from the word");
   AST_SPAN: assert property (span_narrow == $past(gain_range_select))
      else $error("span select not one cycle behind its pin");
   AST_OVER: assert property ($fell(output_clock_true) |->
                              overrange_flag == $past(core_above || core_below))
      else $error("overrange flag does not match the core range levels");
   // Only while the output clock stands high; a relock after a stop may skip one fall
   AST_FALL_LAT: assert property ($fell(sample_clk) && output_clock_true |->
                                  ##2 $fell(output_clock_true))
      else $error("output clock fall not two cycles after sample fall");
   AST_DITHER_STEP: assert property (!$stable(dither_dac) && dither_dac != '0 |->
                                     $past(hold_strobe))
      else $error("dither value moved without a sample instant");

   // Main scenarios reached
   cover property ($fell(output_clock_true) && overrange_flag);
   cover property ($rose(sample_valid));
   cover property ($fell(output_clock_true) && dither_dac != '0);
endmodule : aofc_top_assertions

bind aofc_top aofc_top_assertions i_aofc_top_assertions (.hclk, .hresetn, .sample_clk,
   .gain_range_select, .core_above, .core_below, .dither_dac, .span_narrow, .hold_strobe,
   .data_out, .overrange_flag, .output_clock_true, .output_clock_inverted, .sample_valid);

// [dv/testbench.sv]
// Self-checking bench for the output format and clock control block
`timescale 1ns/1ps
module testbench;
   logic                 hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0]          haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0]           htrans = 2'h0, mode_level = 2'h0;
   logic                 hreadyout, hresp, span_narrow, hold_strobe, sample_valid;
   logic                 sample_clk = 1'b1, gain_range_select = 1'b0, output_scramble_enable = 1'b0;
   logic [15:0]          core_result = 16'h0, data_out;
   logic                 core_above = 1'b0, core_below = 1'b0, overrange_flag;
   logic                 output_clock_true, output_clock_inverted, dith_seen = 1'b0;
   logic [7:0]           dither_dac, run_hi = 8'h0, last_hi = 8'h0;
   logic [31:0]          dhist = 32'h0;
   aofc_pkg::aofc_word_s cap;
   int                   n_fail = 0, num_checks = 0, cyc = 0;

   always #10 hclk = ~hclk;

   aofc_top i_aofc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sample_clk(sample_clk),
      .mode_level(mode_level), .gain_range_select(gain_range_select),
      .output_scramble_enable(output_scramble_enable), .core_result(core_result),
      .core_above(core_above), .core_below(core_below), .dither_dac(dither_dac),
      .span_narrow(span_narrow), .hold_strobe(hold_strobe), .data_out(data_out),
      .overrange_flag(overrange_flag), .output_clock_true(output_clock_true),
      .output_clock_inverted(output_clock_inverted), .sample_valid(sample_valid));

   aofc_capture_model i_aofc_capture_model (.clk_true(output_clock_true), .data(data_out),
      .over(overrange_flag), .descramble(output_scramble_enable), .word(cap));

   // Length of the last high span of the true output clock, and dither activity
   always @(posedge hclk) begin
      cyc++;
      if (dither_dac != 8'h00) dith_seen <= 1'b1;
      // Dither values of the last four samples, oldest in the top byte
      if (hold_strobe) dhist <= {dhist[23:0], dither_dac};
      if (output_clock_true) run_hi <= run_hi + 8'h01;
      else begin
         if (run_hi != 8'h00) last_hi <= run_hi;
         run_hi <= 8'h00;
      end
      if (cyc == 10000) begin
         n_fail++;
         tally_and_finish();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   // One single AHB-Lite transfer; entered just after a rising edge
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rdv);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rdv = hrdata;
   endtask : ahb

   // Sample clock periods: low span first, ends high
   task automatic run(input int n, input int hi, input int lo);
      repeat (n) begin
         sample_clk <= 1'b0;
         repeat (lo) @(posedge hclk);
         sample_clk <= 1'b1;
         repeat (hi) @(posedge hclk);
      end
   endtask : run

   function automatic logic [15:0] fmt(input logic [15:0] v, input logic [1:0] m, input logic s);
      logic [15:0] f;
      f = v ^ {m[1], 15'h0000};
      return s ? f ^ {{15{f[0]}}, 1'b0} : f;
   endfunction : fmt

   task automatic t_format;
      logic [15:0] v;
      for (int m = 0; m < 4; m++) begin
         for (int s = 0; s < 2; s++) begin
            v = 16'h8A53 ^ {m[1:0], 13'h0000, s[0]};
            mode_level <= m[1:0];
            output_scramble_enable <= s[0];
            core_result <= v;
            run(4, 5, 5);
            check({16'h0, data_out}, {16'h0, fmt(v, m[1:0], s[0])});
            check({16'h0, cap.data}, {16'h0, fmt(v, m[1:0], 1'b0)});
            ahb(1'b0, aofc_pkg::OFS_LAST, 32'h0, rd);
            check(rd, {16'h0, fmt(v, m[1:0], s[0])});
            ahb(1'b0, aofc_pkg::OFS_STATUS, 32'h0, rd);
            check({30'h0, rd[9:8]}, {30'h0, m[1:0]});
         end
      end
      ahb(1'b0, 8'h10, 32'h0, rd);
      check(rd, 32'h0);
      $display("t_format done");
   endtask : t_format

   task automatic t_over;
      output_scramble_enable <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         core_above <= (k == 1);
         core_below <= (k == 2);
         run(3, 5, 5);
         check({31'h0, overrange_flag}, {31'h0, k != 0});
         check({31'h0, cap.over}, {31'h0, k != 0});
      end
      core_above <= 1'b0;
      core_below <= 1'b0;
      $display("t_over done");
   endtask : t_over

   task automatic t_gain;
      for (int g = 1; g >= 0; g--) begin
         gain_range_select <= g[0];
         repeat (2) @(posedge hclk);
         check({31'h0, span_narrow}, {31'h0, g[0]});
      end
      $display("t_gain done");
   endtask : t_gain

   task automatic t_stab;
      mode_level <= aofc_pkg::MODE_THIRD;
      run(120, 3, 7);
      check({31'h0, sample_valid}, 32'h1);
      check({24'h0, last_hi}, 32'h5);
      ahb(1'b0, aofc_pkg::OFS_PERIOD, 32'h0, rd);
      check(rd, 32'h0000030A);
      repeat (200) @(posedge hclk);
      ahb(1'b0, aofc_pkg::OFS_STATUS, 32'h0, rd);
      check({31'h0, rd[aofc_pkg::ST_STOP_BIT]}, 32'h1);
      check({31'h0, rd[aofc_pkg::ST_LOCKED_BIT]}, 32'h0);
      run(5, 3, 7);
      check({31'h0, sample_valid}, 32'h0);
      run(110, 3, 7);
      check({31'h0, sample_valid}, 32'h1);
      $display("t_stab done");
   endtask : t_stab

   task automatic t_dither;
      check({31'h0, dith_seen}, 32'h0);
      output_scramble_enable <= 1'b0;
      ahb(1'b1, aofc_pkg::OFS_CTRL, 32'h1, rd);
      ahb(1'b0, aofc_pkg::OFS_CTRL, 32'h0, rd);
      check(rd, 32'h1);
      run(6, 5, 5);
      check({31'h0, dith_seen}, 32'h1);
      check({16'h0, data_out}, {16'h0, core_result - {8'h00, dhist[31:24]}});
      ahb(1'b1, aofc_pkg::OFS_CTRL, 32'h0, rd);
      $display("t_dither done");
   endtask : t_dither

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_format();
      t_over();
      t_gain();
      t_stab();
      t_dither();
      tally_and_finish();
   end
endmodule : testbench

// [hw/aofc_pkg.sv]
// Package for the converter output format and clock control block
package aofc_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ         = 50_000_000;
   localparam int unsigned MAX_RATE_SPS   = 20_000_000;
   localparam int unsigned MIN_RATE_SPS   = 1_000_000;
   localparam int unsigned MIN_HALF_NS    = 20;
   localparam int unsigned RELOCK_CYCLES  = 100;
   // Shortest legal period rounds up, longest rounds down
   localparam int unsigned MIN_PERIOD_CYC = (CLK_HZ + MAX_RATE_SPS - 1) / MAX_RATE_SPS;
   localparam int unsigned MAX_PERIOD_CYC = CLK_HZ / MIN_RATE_SPS;
   localparam int unsigned MIN_HALF_CYC   = (MIN_HALF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned STOP_CYC       = 2 * MAX_PERIOD_CYC;
   localparam int unsigned CNT_W          = 8;

   // ----------------------------------------------------------------
   // Data path
   // ----------------------------------------------------------------
   localparam int unsigned DATA_W   = 16;
   localparam int unsigned DITHER_W = 8;
   localparam int unsigned LFSR_W   = 23;
   localparam int unsigned LFSR_TAP = 18;
   localparam int unsigned PIPE_D   = 4;
   localparam logic [LFSR_W-1:0] LFSR_SEED = 23'h000001;

   // ----------------------------------------------------------------
   // Register map and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_PERIOD = 8'h08;
   localparam logic [7:0] OFS_LAST   = 8'h0C;
   localparam int unsigned CTRL_DITHER_BIT = 0;
   localparam logic       CTRL_RESET = 1'b0;
   localparam int unsigned ST_LOCKED_BIT = 0;
   localparam int unsigned ST_STOP_BIT   = 1;
   localparam int unsigned ST_FAST_BIT   = 2;
   localparam int unsigned ST_SLOW_BIT   = 3;
   localparam int unsigned ST_SHORT_BIT  = 4;
   localparam int unsigned ST_MODE_LSB   = 8;

   // Four-level mode pin, already resolved to a two-bit code
   localparam logic [1:0] MODE_GND   = 2'h0;
   localparam logic [1:0] MODE_THIRD = 2'h1;
   localparam logic [1:0] MODE_TWO3  = 2'h2;
   localparam logic [1:0] MODE_VDD   = 2'h3;

   typedef struct packed {
      logic              over;
      logic [DATA_W-1:0] data;
   } aofc_word_s;

   typedef struct packed {
      logic       twos;
      logic       stab_on;
   } aofc_mode_s;
endpackage : aofc_pkg

// [hw/aofc_top.sv]
// Output format, clock stabilizer, dither and randomizer control
`timescale 1ns/1ps
// Operation
// - Gain range pin low picks 2.5 V span, high picks 1.667 V span.
// - Stabilizer on: sample on falling edge, rising edge made internally.
// - Stabilizer on: accept 30 to 70 percent duty, internal clock 50 percent.
// - After a long clock stop, 100 cycles to relock; samples meanwhile invalid if stabilizer on.
// - Mode code sets output format and stabilizer per the four levels.
// - Overrange flag high while the sample is outside the convertible span.
// - Delayed sample clock is output as true and inverted pair.
// - Data outputs change as true clock falls and inverted clock rises.
// - Randomizing XORs each bit above the LSB with the LSB.
// - Randomizer leaves LSB, overrange flag and clock pair untouched.
// - Randomize only while scramble enable pin is high.
// - Dither from long pseudo-random sequence drives DAC, subtracted digitally.
// - Each result is a 16-bit parallel word plus overrange flag.
module aofc_top (
   // Clock and reset
   input  wire  logic                        hclk,
   input  wire  logic                        hresetn,
   // AHB-Lite slave
   input  wire  logic                        hsel,
   input  wire  logic [31:0]                 haddr,
   input  wire  logic [1:0]                  htrans,
   input  wire  logic                        hwrite,
   input  wire  logic [2:0]                  hsize,
   input  wire  logic [31:0]                 hwdata,
   input  wire  logic                        hready,
   output logic       [31:0]                 hrdata,
   output logic                              hreadyout,
   output logic                              hresp,
   // Device pins
   input  wire  logic                        sample_clk,
   input  wire  logic [1:0]                  mode_level,
   input  wire  logic                        gain_range_select,
   input  wire  logic                        output_scramble_enable,
   // Converter core
   input  wire  logic [aofc_pkg::DATA_W-1:0] core_result,
   input  wire  logic                        core_above,
   input  wire  logic                        core_below,
   output logic       [aofc_pkg::DITHER_W-1:0] dither_dac,
   output logic                              span_narrow,
   output logic                              hold_strobe,
   // Parallel output
   output logic       [aofc_pkg::DATA_W-1:0] data_out,
   output logic                              overrange_flag,
   output logic                              output_clock_true,
   output logic                              output_clock_inverted,
   output logic                              sample_valid
);
   localparam int unsigned CW = aofc_pkg::CNT_W;
   localparam int unsigned DW = aofc_pkg::DATA_W;

   // ----------------------------------------------------------------
   // Mode decode and pins
   // ----------------------------------------------------------------
   aofc_pkg::aofc_mode_s mode;
   always_comb begin
      unique case (mode_level)
         aofc_pkg::MODE_GND:   mode = '{twos: 1'b0, stab_on: 1'b0};
         aofc_pkg::MODE_THIRD: mode = '{twos: 1'b0, stab_on: 1'b1};
         aofc_pkg::MODE_TWO3:  mode = '{twos: 1'b1, stab_on: 1'b1};
         aofc_pkg::MODE_VDD:   mode = '{twos: 1'b1, stab_on: 1'b0};
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         span_narrow <= 1'b0;
      end else begin
         span_narrow <= gain_range_select;
      end
   end

   // ----------------------------------------------------------------
   // Sample clock edges and period measurement
   // ----------------------------------------------------------------
   logic          clk_in_reg;
   logic          fall_evt;
   logic          rise_evt;
   logic [CW-1:0] since_fall_reg;
   logic [CW-1:0] since_rise_reg;
   logic [CW-1:0] period_reg;
   logic [CW-1:0] high_reg;
   logic          stopped_reg;
   logic          fast_reg;
   logic          slow_reg;
   logic          short_reg;

   assign fall_evt = clk_in_reg & ~sample_clk;
   assign rise_evt = ~clk_in_reg & sample_clk;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         // Idle-high clock: avoids a false rise right after reset
         clk_in_reg     <= 1'b1;
         since_fall_reg <= '0;
         since_rise_reg <= '0;
         period_reg     <= '0;
         high_reg       <= '0;
      end else begin
         clk_in_reg <= sample_clk;
         if (fall_evt) begin
            since_fall_reg <= CW'(1);
            period_reg     <= since_fall_reg;
            high_reg       <= since_rise_reg;
         end else if (since_fall_reg != '1) begin
            since_fall_reg <= since_fall_reg + CW'(1);
         end
         if (rise_evt) begin
            since_rise_reg <= CW'(1);
         end else if (since_rise_reg != '1) begin
            since_rise_reg <= since_rise_reg + CW'(1);
         end
      end
   end

   // Rate and half-period checks only report; the clock source owns them
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fast_reg    <= 1'b0;
         slow_reg    <= 1'b0;
         short_reg   <= 1'b0;
         stopped_reg <= 1'b1;
      end else begin
         if (fall_evt) begin
            fast_reg  <= since_fall_reg < CW'(aofc_pkg::MIN_PERIOD_CYC);
            slow_reg  <= since_fall_reg > CW'(aofc_pkg::MAX_PERIOD_CYC);
            short_reg <= !mode.stab_on &&
                         (since_rise_reg < CW'(aofc_pkg::MIN_HALF_CYC));
         end
         if (fall_evt) begin
            stopped_reg <= 1'b0;
         end else if (since_fall_reg >= CW'(aofc_pkg::STOP_CYC)) begin
            stopped_reg <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Duty cycle stabilizer
   // ----------------------------------------------------------------
   logic          int_clk_reg;
   logic [6:0]    lock_cnt_reg;
   logic          locked;

   assign locked = lock_cnt_reg == 7'(aofc_pkg::RELOCK_CYCLES);

   // External rise ignored when on; internal rise at half the period
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         int_clk_reg <= 1'b0;
      end else if (mode.stab_on) begin
         if (fall_evt) begin
            int_clk_reg <= 1'b0;
         end else if (since_fall_reg == (period_reg >> 1)) begin
            int_clk_reg <= 1'b1;
         end
      end else begin
         int_clk_reg <= sample_clk;
      end
   end

   // A long stop restarts the lock count
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lock_cnt_reg <= '0;
      end else if (stopped_reg && !fall_evt) begin
         lock_cnt_reg <= '0;
      end else if (fall_evt && !locked) begin
         lock_cnt_reg <= lock_cnt_reg + 7'(1);
      end
   end

   // ----------------------------------------------------------------
   // Dither generator and delay line
   // ----------------------------------------------------------------
   logic                                   dither_en_reg;
   logic [aofc_pkg::LFSR_W-1:0]            lfsr_reg;
   logic [aofc_pkg::DITHER_W-1:0]          dly_reg [aofc_pkg::PIPE_D];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lfsr_reg <= aofc_pkg::LFSR_SEED;
      end else if (fall_evt) begin
         lfsr_reg <= {lfsr_reg[aofc_pkg::LFSR_W-2:0],
                      lfsr_reg[aofc_pkg::LFSR_W-1] ^
                      lfsr_reg[aofc_pkg::LFSR_TAP-1]};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dither_dac <= '0;
      end else if (fall_evt) begin
         dither_dac <= dither_en_reg ? lfsr_reg[aofc_pkg::DITHER_W-1:0] : '0;
      end
   end

   // Core latency: each value follows its sample to the result
   for (genvar i = 0; i < aofc_pkg::PIPE_D; i++) begin : g_dly
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            dly_reg[i] <= '0;
         end else if (fall_evt) begin
            dly_reg[i] <= (i == 0) ? dither_dac : dly_reg[(i == 0) ? 0 : i - 1];
         end
      end
   end

   assign hold_strobe = fall_evt;

   // ----------------------------------------------------------------
   // Output word
   // ----------------------------------------------------------------
   aofc_pkg::aofc_word_s word;
   logic [DW-1:0]        clean;
   logic [DW-1:0]        fmt;

   always_comb begin
      clean = core_result - {{(DW - aofc_pkg::DITHER_W){1'b0}},
                             dly_reg[aofc_pkg::PIPE_D-1]};
      fmt   = clean;
      fmt[DW-1] = clean[DW-1] ^ mode.twos;
      word.over = core_above | core_below;
      word.data = fmt;
      if (output_scramble_enable) begin
         word.data[DW-1:1] = fmt[DW-1:1] ^ {(DW - 1){fmt[0]}};
      end
   end

   // Clock pair delayed one cycle; the word moves as the true clock falls
   logic int_clk_d_reg;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         int_clk_d_reg         <= 1'b0;
         output_clock_true     <= 1'b0;
         output_clock_inverted <= 1'b1;
      end else begin
         int_clk_d_reg         <= int_clk_reg;
         output_clock_true     <= int_clk_reg;
         output_clock_inverted <= ~int_clk_reg;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         data_out       <= '0;
         overrange_flag <= 1'b0;
         sample_valid   <= 1'b0;
      end else if (int_clk_d_reg && !int_clk_reg) begin
         data_out       <= word.data;
         overrange_flag <= word.over;
         sample_valid   <= locked || !mode.stab_on;
      end
   end

   // ----------------------------------------------------------------
   // AHB-Lite register slave, zero wait states
   // ----------------------------------------------------------------
   logic       wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic       take;

   assign take      = hsel && htrans[1] && hready;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= '0;
      end else begin
         wr_pend_reg <= take && hwrite;
         wr_addr_reg <= haddr[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dither_en_reg <= aofc_pkg::CTRL_RESET;
      end else if (wr_pend_reg && wr_addr_reg == aofc_pkg::OFS_CTRL) begin
         dither_en_reg <= hwdata[aofc_pkg::CTRL_DITHER_BIT];
      end
   end

   // Read data is loaded at the address phase so it stands in the data phase
   logic [31:0] rd_next;
   always_comb begin
      rd_next = '0;
      unique case (haddr[7:0])
         aofc_pkg::OFS_CTRL:   rd_next[aofc_pkg::CTRL_DITHER_BIT] = dither_en_reg;
         aofc_pkg::OFS_STATUS: begin
            rd_next[aofc_pkg::ST_LOCKED_BIT] = locked;
            rd_next[aofc_pkg::ST_STOP_BIT]   = stopped_reg;
            rd_next[aofc_pkg::ST_FAST_BIT]   = fast_reg;
            rd_next[aofc_pkg::ST_SLOW_BIT]   = slow_reg;
            rd_next[aofc_pkg::ST_SHORT_BIT]  = short_reg;
            rd_next[aofc_pkg::ST_MODE_LSB +: 2] = mode_level;
         end
         aofc_pkg::OFS_PERIOD: rd_next = {16'h0000, high_reg, period_reg};
         aofc_pkg::OFS_LAST:   rd_next = {15'h0000, overrange_flag, data_out};
         default:              rd_next = '0;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= '0;
      end else if (take && !hwrite) begin
         hrdata <= rd_next;
      end
   end
endmodule : aofc_top
